//--- pkg/mtx_pkg.sv
// mtx_pkg: constants and beat layout for the transmit stream client
// assumes a 64-bit stream toward the mac, one clock, no register bus
`default_nettype none
package mtx_pkg;
    localparam int DATA_W = 64;
    localparam int LANES = 8;
    localparam int LANE_W = 8;
    localparam int CNT_W = 16;
    localparam int LCNT_W = 4;
    localparam logic [CNT_W-1:0] HDR_BYTES = 16'h000e;
    localparam logic [CNT_W-1:0] MIN_FRAME_BYTES = 16'h003c;
    localparam logic [CNT_W-1:0] CNT_ZERO = 16'h0000;
    localparam logic [LCNT_W-1:0] LANES_CNT = 4'h8;
    localparam logic [7:0] IFG_RST = 8'h00;

    typedef struct packed {
        logic [DATA_W-1:0] data;
        logic [LANES-1:0] keep;
        logic last;
        logic user;
    } mtx_beat_t;

    typedef enum logic [0:0] {
        MTX_FWD,
        MTX_PAD
    } mtx_state_t;
endpackage : mtx_pkg
`default_nettype wire

//--- src/mtx_client.sv
// mtx_client: client logic feeding the transmit stream port of a 10g mac
// assumes the mac runs on clk and answers with macReady on the same clock
// Notes on behaviour
// - lane n is bits 8n+7:8n, keep n
// - raise valid with first word, same cycle
// - hold beat until ready, then next beat
// - last for one beat, partial keep allowed
// - header in-band: da lane0, sa lane6
// - in-band fcs: client pads short frames
// - abort by user flag with valid high
// - aborted frame still carries da, sa, type
// - aborted frames are never resent here
// - valid may stay high across frames; here macValid drops for a cycle after every forwarded user beat, frame end or not, unless pad beats follow it
`default_nettype none
module mtx_client
    import mtx_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    // user side
    input wire logic usrValid,
    input wire logic [mtx_pkg::DATA_W-1:0] usrData,
    input wire logic [mtx_pkg::LANES-1:0] usrKeep,
    input wire logic usrLast,
    input wire logic usrAbort,
    output logic usrReady,
    input wire logic fcsInband,
    input wire logic [7:0] ifgCfg,
    // mac side
    output logic macRstN,
    output logic macValid,
    output logic [mtx_pkg::DATA_W-1:0] macData,
    output logic [mtx_pkg::LANES-1:0] macKeep,
    output logic macLast,
    output logic macUser,
    input wire logic macReady,
    output logic [7:0] macIfgDelay
);
    import mtx_pkg::*;

    mtx_beat_t slot_r, slot_nxt;
    logic slotValid_r, slotValid_nxt;
    logic usrReady_r, usrReady_nxt;
    mtx_state_t state_r, state_nxt;
    logic [CNT_W-1:0] count_r, count_nxt;
    logic abortPend_r, abortPend_nxt;
    logic macRstN_r;
    logic [7:0] ifgDelay_r;
    logic [LCNT_W-1:0] padLanes;
    logic [LANES-1:0] padKeep;
    logic [CNT_W-1:0] padRem;

    function automatic logic [LCNT_W-1:0] popCount(input logic [LANES-1:0] k);
        logic [LCNT_W-1:0] c;
        c = '0;
        for (int i = 0; i < LANES; i++) begin
            c = c + LCNT_W'(k[i]);
        end
        return c;
    endfunction : popCount

    assign padRem = MIN_FRAME_BYTES - count_r;
    assign padLanes = (padRem > CNT_W'(LANES_CNT)) ? LANES_CNT : padRem[LCNT_W-1:0];

    mtx_keep_mask #(
        .LANES(LANES),
        .LCNT_W(LCNT_W)
    ) uPadMask (
        .laneCnt(padLanes),
        .keep(padKeep)
    );

    always_comb begin
        logic take;
        logic slotFree;
        logic abortNow;
        logic [CNT_W-1:0] total;
        take = 1'b0;
        slotFree = 1'b0;
        abortNow = 1'b0;
        total = '0;
        slot_nxt = slot_r;
        slotValid_nxt = slotValid_r;
        state_nxt = state_r;
        count_nxt = count_r;
        abortPend_nxt = abortPend_r;
        // beat stays put until the mac takes it
        if (slotValid_r && macReady) begin
            slotValid_nxt = 1'b0;
        end
        slotFree = !slotValid_r || macReady;
        case (state_r)
            MTX_FWD: begin
                take = usrValid && usrReady_r;
                if (take) begin
                    total = count_r + CNT_W'(popCount(usrKeep));
                    abortNow = usrAbort || abortPend_r;
                    // data and keep pass lane for lane
                    slot_nxt.data = usrData;
                    slot_nxt.keep = usrKeep;
                    // abort is held back until the header has gone out or the frame's last beat arrives
                    slot_nxt.user = abortNow && (total >= HDR_BYTES || usrLast);
                    abortPend_nxt = abortNow && !(total >= HDR_BYTES || usrLast);
                    slotValid_nxt = 1'b1; // valid and data rise together
                    if (usrLast && fcsInband && total < MIN_FRAME_BYTES) begin
                        slot_nxt.last = 1'b0; // short frame, pad it ourselves
                        state_nxt = MTX_PAD;
                        count_nxt = total;
                    end else if (usrLast) begin
                        slot_nxt.last = 1'b1; // single last beat, partial
                        count_nxt = CNT_ZERO;
                        abortPend_nxt = 1'b0;
                    end else begin
                        slot_nxt.last = 1'b0;
                        count_nxt = total;
                    end
                end
            end
            MTX_PAD: begin
                if (slotFree) begin
                    slot_nxt.data = '0;
                    slot_nxt.keep = padKeep; // zero bytes up to minimum length
                    slot_nxt.user = 1'b0;
                    slot_nxt.last = (padRem <= CNT_W'(LANES_CNT));
                    slotValid_nxt = 1'b1;
                    count_nxt = count_r + CNT_W'(padLanes);
                    if (padRem <= CNT_W'(LANES_CNT)) begin
                        state_nxt = MTX_FWD;
                        count_nxt = CNT_ZERO;
                    end
                end
            end
            default: begin
                state_nxt = MTX_FWD;
            end
        endcase
        // the next user beat may be taken once the slot empties; macValid drops for a cycle first
        usrReady_nxt = (state_nxt == MTX_FWD) && !slotValid_nxt;
    end

    // aborted frames are dropped for good; the user resubmits if wanted
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            slot_r <= '0;
            slotValid_r <= 1'b0;
            usrReady_r <= 1'b0;
            state_r <= MTX_FWD;
            count_r <= CNT_ZERO;
            abortPend_r <= 1'b0;
        end else begin
            slot_r <= slot_nxt;
            slotValid_r <= slotValid_nxt;
            usrReady_r <= usrReady_nxt;
            state_r <= state_nxt;
            count_r <= count_nxt;
            abortPend_r <= abortPend_nxt;
        end
    end

    // mac reset follows ours one cycle late; gap extension is registered
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            macRstN_r <= 1'b0;
            ifgDelay_r <= IFG_RST;
        end else begin
            macRstN_r <= 1'b1;
            ifgDelay_r <= ifgCfg;
        end
    end

    assign usrReady = usrReady_r;
    assign macRstN = macRstN_r;
    assign macValid = slotValid_r;
    assign macData = slot_r.data;
    assign macKeep = slot_r.keep;
    assign macLast = slot_r.last;
    assign macUser = slot_r.user;
    assign macIfgDelay = ifgDelay_r;
endmodule : mtx_client
`default_nettype wire

//--- src/mtx_keep_mask.sv
// mtx_keep_mask: keep bits for the first n byte lanes
// assumes n never exceeds the lane count
`default_nettype none
module mtx_keep_mask #(
    parameter int LANES = 8,
    parameter int LCNT_W = 4
) (
    input wire logic [LCNT_W-1:0] laneCnt,
    output logic [LANES-1:0] keep
);
    always_comb begin
        for (int i = 0; i < LANES; i++) begin
            keep[i] = (LCNT_W'(i) < laneCnt);
        end
    end
endmodule : mtx_keep_mask
`default_nettype wire

//--- tb/mtx_checker.sv
// mtx_checker: port assertions for mtx_client
// assumes it is bound to mtx_client, one clock
`default_nettype none
module mtx_checker
    import mtx_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic usrValid,
    input wire logic usrReady,
    input wire logic usrLast,
    input wire logic usrAbort,
    input wire logic [mtx_pkg::DATA_W-1:0] usrData,
    input wire logic [7:0] ifgCfg,
    input wire logic macRstN,
    input wire logic macValid,
    input wire logic macReady,
    input wire logic [mtx_pkg::DATA_W-1:0] macData,
    input wire logic macLast,
    input wire logic macUser,
    input wire logic [7:0] macIfgDelay
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    hold_take_a: assert property (macValid && !macReady |=> macValid && $stable(macData)) else $error("beat moved");
    beat_pass_a: assert property (usrValid && usrReady |=> macValid && macData == $past(usrData)) else $error("beat lost");
    ready_drop_a: assert property (usrValid && usrReady |=> !usrReady) else $error("ready held after take");
    slot_full_a: assert property (macValid && !macReady |-> !usrReady) else $error("ready while slot full");
    last_end_a: assert property (macValid && macReady && macLast |=> !macValid) else $error("beat after last");
    abort_flag_a: assert property (usrValid && usrReady && usrAbort && usrLast |=> macUser) else $error("no abort");
    gap_pass_a: assert property (rst_n && $past(rst_n) |=> macIfgDelay == $past(ifgCfg)) else $error("gap value");
    reset_hold_a: assert property (!macRstN |-> !macValid && !usrReady) else $error("active in reset");
    cover property (macValid && macReady && macUser);
    cover property (macValid && !macReady);
    cover property (usrValid && usrReady && usrLast);
endmodule : mtx_checker
bind mtx_client mtx_checker chk_u (.*);
`default_nettype wire

//--- tb/mtx_mac_model.sv
// mtx_mac_model: mac stream port, counts bytes and flags underruns per frame
// assumes one clock; slow stalls ready every other cycle
`default_nettype none
module mtx_mac_model
    import mtx_pkg::*;
(
    input wire logic clk,
    input wire logic slow,
    input wire logic macRstN,
    input wire logic macValid,
    input wire logic [mtx_pkg::LANES-1:0] macKeep,
    input wire logic macLast,
    input wire logic macUser,
    input wire logic [7:0] macIfgDelay,
    output logic macReady,
    output logic [mtx_pkg::CNT_W-1:0] bytes,
    output logic bad,
    output logic done
);
    timeunit 1ns;
    timeprecision 1ns;
    // preamble, crc, idles and terminate live past this port; not modelled
    // no custom preamble here, so ready never runs on past a frame
    logic [8:0] gap;
    logic tick;
    // ready drops for the whole gap, so a waiting client beat is held back
    assign macReady = macRstN && gap == 9'h000 && !(slow && tick);
    always @(posedge clk) begin
        tick <= !tick;
        if (!macRstN) begin
            gap <= 9'h000;
            tick <= 1'b0;
            done <= 1'b1;
        end else if (macValid && macReady) begin
            bytes <= (done ? CNT_ZERO : bytes) + 16'($countones(macKeep));
            bad <= (!done && bad) || macUser;
            done <= macLast;
            gap <= macLast ? 9'h003 + 9'(macIfgDelay) : 9'h000;
        end else if (gap != 9'h000) begin
            gap <= gap - 9'h001;
        end
    end
endmodule : mtx_mac_model
`default_nettype wire

//--- tb/tb_mtx_client.sv
// tb_mtx_client: scenario bench for mtx_client against the mac model
// assumes a 50 ns clock; inputs change on the falling edge
`default_nettype none
module tb_mtx_client import mtx_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic usrValid = 1'b0;
    logic [DATA_W-1:0] usrData = 64'h0;
    logic [LANES-1:0] usrKeep = 8'h00;
    logic usrLast = 1'b0;
    logic usrAbort = 1'b0;
    logic fcsInband = 1'b0;
    logic [7:0] ifgCfg = 8'h00;
    logic slow = 1'b0;
    logic usrReady, macRstN, macValid, macLast, macUser, macReady, done, bad;
    logic [DATA_W-1:0] macData;
    logic [LANES-1:0] macKeep;
    logic [7:0] macIfgDelay;
    logic [CNT_W-1:0] bytes;
    int num_errors = 0;
    int num_checks = 0;
    always #25 clk = !clk;
    mtx_client dut_u (.*);
    mtx_mac_model mac_u (.*);
    task automatic end_sim;
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : end_sim
    task automatic expect_eq(input logic ok, input string what);
        num_checks++;
        if (ok !== 1'b1) begin
            num_errors++;
            $display("unexpected at %0t: %s", $time, what);
        end
    endtask : expect_eq
    // one frame of nb bytes; waits until the mac has taken its final beat
    task automatic frame(input int nb, input logic inb, input logic ab);
        int r;
        int n;
        fcsInband = inb;
        for (r = nb; r > 0; r -= 8) begin
            usrValid = 1'b1;
            usrData = {8{8'(r)}};
            usrKeep = r >= 8 ? 8'hff : 8'hff >> 3'(8 - r);
            usrLast = r <= 8;
            usrAbort = ab && r == nb;
            for (n = 0; n < 40 && usrReady !== 1'b1; n++) @(negedge clk);
            expect_eq(usrReady === 1'b1, "ready timeout");
            @(negedge clk);
        end
        usrValid = 1'b0;
        usrLast = 1'b0;
        usrAbort = 1'b0;
        for (n = 0; n < 200 && !(done === 1'b1 && macValid === 1'b0); n++) @(negedge clk);
        expect_eq(n < 200, "frame timeout");
        expect_eq(bytes === 16'(inb && nb < 60 ? 60 : nb), "byte count");
        expect_eq(bad === ab, "underrun flag");
    endtask : frame
    task automatic t_plain;
        frame(64, 1'b0, 1'b0);
        frame(13, 1'b0, 1'b0);
    endtask : t_plain
    task automatic t_pad;
        frame(40, 1'b1, 1'b0);
        frame(59, 1'b1, 1'b0);
        frame(60, 1'b1, 1'b0);
    endtask : t_pad
    task automatic t_abort;
        slow = 1'b1;
        frame(30, 1'b0, 1'b1);
        frame(30, 1'b0, 1'b0);
        frame(8, 1'b0, 1'b1);
        slow = 1'b0;
    endtask : t_abort
    task automatic t_gap;
        ifgCfg = 8'h07;
        repeat (2) @(negedge clk);
        expect_eq(macIfgDelay === 8'h07, "gap extension");
        frame(16, 1'b0, 1'b0);
    endtask : t_gap
    initial begin
        repeat (4) @(negedge clk);
        expect_eq(macRstN === 1'b0 && usrReady === 1'b0, "reset state");
        rst_n = 1'b1;
        t_plain();
        t_pad();
        t_abort();
        t_gap();
        end_sim();
    end
    // the whole run needs well under a thousand cycles
    initial begin
        repeat (5000) @(posedge clk);
        num_errors++;
        end_sim();
    end
endmodule : tb_mtx_client
`default_nettype wire
